/* hdl/mdc_pkg.sv */
// Package with register map, field layout and startup encodings for the debug control register
package mdc_pkg;
  localparam logic [7:0] MDC_DEBUG_CTRL_OFS = 8'hEC;
  localparam logic [31:0] MDC_DEBUG_CTRL_RST = 32'h00000000;
  localparam int MDC_REFERENCE_FLAG_A_BIT = 31;
  localparam int MDC_SPEED_REF_MSB = 30;
  localparam int MDC_SPEED_REF_LSB = 16;
  localparam int MDC_LOOP_DIS_BIT = 15;
  localparam int MDC_HOLD_ALIGN_BIT = 14;
  localparam int MDC_HOLD_SLOW_BIT = 13;
  localparam int MDC_HOLD_IPD_BIT = 12;
  localparam int MDC_HOLD_ISD_BIT = 11;
  localparam int MDC_ANGLE_SEL_BIT = 10;
  localparam logic [31:0] MDC_WRITE_MASK = 32'hFFFFFC00;
  localparam logic [1:0] MDC_SRC_REGISTER = 2'h2;
  localparam logic [14:0] MDC_REF_FULL_SCALE_M1 = 15'h7FFF;
  localparam logic [1:0] MDC_START_ALIGN = 2'h0;
  localparam logic [1:0] MDC_START_DOUBLE_ALIGN = 2'h1;
  localparam logic [1:0] MDC_START_SLOW_CYCLE = 2'h2;
  localparam logic [1:0] MDC_START_IPD = 2'h3;
  typedef enum logic [2:0] {
    MDC_ST_IDLE, MDC_ST_ISD, MDC_ST_ALIGN, MDC_ST_SLOW, MDC_ST_IPD, MDC_ST_RUN
  } mdc_state_t;
endpackage : mdc_pkg

/* hdl/mdc_speed_select.sv */
// Speed reference source selector for the debug control register
`timescale 1ns/1ps
module mdc_speed_select
  import mdc_pkg::*;
(
  input wire logic i_reference_flag_a,
  input wire logic [1:0] i_source_mode,
  input wire logic [14:0] i_reg_ref,
  input wire logic [14:0] i_ext_ref,
  output logic [14:0] o_ref,
  output logic o_from_reg
);
  // Reference_flag_a wins over mode; mode 2 also takes the register field
  always_comb begin
    o_from_reg = i_reference_flag_a || (i_source_mode == MDC_SRC_REGISTER);
    o_ref = o_from_reg ? i_reg_ref : i_ext_ref;
  end
endmodule : mdc_speed_select

/* hdl/mdc_debug_ctrl.sv */
// Debug control register and startup sequence hold logic of the motor controller
`timescale 1ns/1ps
// How it works
// - A 32-bit debug control register sits at offset ECh and clears to zero on reset.
// - Bit 31 set takes the speed command from the register field, else from the external input unless source mode is 2.
// - Field bits 30..16 is the reference when reference_flag_a is set or source mode is 2.
// - The field value counts full scale as 32768, so percent equals value/32768*100.
// - Bit 15 set forces open-loop commutation, clear leaves closed loop on.
// - Bit 14 with align or double-align startup keeps the sequence in align.
// - Bit 13 with slow-first-cycle startup keeps the sequence in slow first cycle.
// - Bit 12 with position-detect startup keeps the sequence in position detect.
// - Bit 11 with speed detect enabled keeps the sequence in speed detect while the bit stays set.
// - Bit 10 picks the primary align angle at 0 and the alternate lock angle at 1.
module mdc_debug_ctrl
  import mdc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic [1:0] i_source_mode,
  input wire logic [14:0] i_ext_ref,
  input wire logic [1:0] i_startup_method_select,
  input wire logic i_speed_detect_enable,
  input wire logic i_start,
  input wire logic i_stage_done,
  input wire logic [7:0] i_align_angle,
  input wire logic [7:0] i_alternate_rotor_lock_angle,
  output logic [31:0] o_rdata,
  output logic [14:0] o_speed_cmd,
  output logic o_cmd_from_reg,
  output logic o_feedback_loop_disable,
  output logic [7:0] o_lock_angle,
  output logic [2:0] o_startup_state
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] rdata;
    logic [14:0] speed_cmd;
    logic from_reg;
    logic loop_dis;
    logic [7:0] angle;
    mdc_state_t st;
  } mdc_regs_t;

  mdc_regs_t state_ff;
  mdc_regs_t nxt_state;
  logic [14:0] sel_ref;
  logic sel_from_reg;
  logic hold_align;
  logic hold_slow;
  logic hold_ipd;
  logic hold_isd;
  logic [31:0] wr_ctrl;

  // Register word after this cycle's write; kept apart from nxt_state so the
  // selector does not form a loop through the state copy
  always_comb begin
    wr_ctrl = state_ff.ctrl;
    if (i_wr_en && i_addr == MDC_DEBUG_CTRL_OFS) begin
      wr_ctrl = i_wdata & MDC_WRITE_MASK;
    end
  end

  // Source choice uses the next register value so the command follows a write in one cycle
  mdc_speed_select mdc_speed_select_inst (
    .i_reference_flag_a(wr_ctrl[MDC_REFERENCE_FLAG_A_BIT]),
    .i_source_mode(i_source_mode),
    .i_reg_ref(wr_ctrl[MDC_SPEED_REF_MSB:MDC_SPEED_REF_LSB]),
    .i_ext_ref(i_ext_ref),
    .o_ref(sel_ref),
    .o_from_reg(sel_from_reg)
  );

  // Hold conditions from the stored register bits
  always_comb begin
    hold_align = state_ff.ctrl[MDC_HOLD_ALIGN_BIT];
    hold_slow = state_ff.ctrl[MDC_HOLD_SLOW_BIT];
    hold_ipd = state_ff.ctrl[MDC_HOLD_IPD_BIT];
    hold_isd = state_ff.ctrl[MDC_HOLD_ISD_BIT];
  end

  // Next state of register, readback, outputs and startup sequence
  always_comb begin
    nxt_state = state_ff;
    nxt_state.ctrl = wr_ctrl;
    // Unmapped reads return zero; reserved bits are never stored so they read zero
    nxt_state.rdata = (i_rd_en && i_addr == MDC_DEBUG_CTRL_OFS) ? state_ff.ctrl : 32'h00000000;
    // Field is passed raw; consumers scale it against a 32768 full scale
    nxt_state.speed_cmd = sel_ref;
    nxt_state.from_reg = sel_from_reg;
    nxt_state.loop_dis = nxt_state.ctrl[MDC_LOOP_DIS_BIT];
    nxt_state.angle = nxt_state.ctrl[MDC_ANGLE_SEL_BIT] ? i_alternate_rotor_lock_angle
                                                       : i_align_angle;
    case (state_ff.st)
      MDC_ST_IDLE: begin
        if (i_start) begin
          if (i_speed_detect_enable) begin
            nxt_state.st = MDC_ST_ISD;
          end else begin
            nxt_state.st = MDC_ST_ALIGN;
          end
        end
      end
      MDC_ST_ISD: begin
        // Held forever while the hold bit stays set
        if (i_stage_done && !hold_isd) begin
          nxt_state.st = MDC_ST_ALIGN;
        end
      end
      MDC_ST_ALIGN: begin
        // Method dispatch happens at align entry in this simplified sequence
        if (i_startup_method_select == MDC_START_SLOW_CYCLE) begin
          nxt_state.st = MDC_ST_SLOW;
        end else if (i_startup_method_select == MDC_START_IPD) begin
          nxt_state.st = MDC_ST_IPD;
        end else if (i_stage_done && !hold_align) begin
          nxt_state.st = MDC_ST_RUN;
        end
      end
      MDC_ST_SLOW: begin
        if (i_stage_done && !hold_slow) begin
          nxt_state.st = MDC_ST_RUN;
        end
      end
      MDC_ST_IPD: begin
        if (i_stage_done && !hold_ipd) begin
          nxt_state.st = MDC_ST_RUN;
        end
      end
      MDC_ST_RUN: begin
        nxt_state.st = MDC_ST_RUN;
      end
      default: begin
        nxt_state.st = MDC_ST_IDLE;
      end
    endcase
  end

  // Single register stage; synchronous active-low reset
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      state_ff <= '{ctrl: MDC_DEBUG_CTRL_RST, rdata: 32'h00000000, speed_cmd: 15'h0000,
                    from_reg: 1'b0, loop_dis: 1'b0, angle: 8'h00, st: MDC_ST_IDLE};
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Every output is a field of the registered state
  always_comb begin
    o_rdata = state_ff.rdata;
    o_speed_cmd = state_ff.speed_cmd;
    o_cmd_from_reg = state_ff.from_reg;
    o_feedback_loop_disable = state_ff.loop_dis;
    o_lock_angle = state_ff.angle;
    o_startup_state = state_ff.st;
  end

  // Checks; outputs other than o_rdata lag the register word by nothing, the inputs by one cycle
  reset_zero_a: assert property (
    @(posedge i_clock) !i_nrst |=> state_ff.ctrl == MDC_DEBUG_CTRL_RST)
    else $error("register not cleared by reset");
  read_back_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    ##1 ($past(i_rd_en) && $past(i_addr) == MDC_DEBUG_CTRL_OFS)
      |-> o_rdata == $past(state_ff.ctrl))
    else $error("read data is not the stored word");
  reference_flag_a_src_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    state_ff.ctrl[MDC_REFERENCE_FLAG_A_BIT]
      |-> o_speed_cmd == state_ff.ctrl[MDC_SPEED_REF_MSB:MDC_SPEED_REF_LSB])
    else $error("reference_flag_a did not select register reference");
  mode_src_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    ##1 ($past(i_source_mode) == MDC_SRC_REGISTER) |-> o_cmd_from_reg)
    else $error("source mode 2 did not select register");
  ext_src_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    ##1 (!state_ff.ctrl[MDC_REFERENCE_FLAG_A_BIT] && $past(i_source_mode) != MDC_SRC_REGISTER)
      |-> o_speed_cmd == $past(i_ext_ref))
    else $error("external reference not used");
  raw_field_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    o_cmd_from_reg |-> o_speed_cmd == state_ff.ctrl[MDC_SPEED_REF_MSB:MDC_SPEED_REF_LSB])
    else $error("register reference was scaled or altered");
  loop_dis_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    o_feedback_loop_disable == state_ff.ctrl[MDC_LOOP_DIS_BIT])
    else $error("loop disable does not follow bit 15");
  align_hold_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    (state_ff.st == MDC_ST_ALIGN && hold_align
      && (i_startup_method_select == MDC_START_ALIGN
      || i_startup_method_select == MDC_START_DOUBLE_ALIGN)) |=> state_ff.st == MDC_ST_ALIGN)
    else $error("left align while held");
  slow_hold_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    (state_ff.st == MDC_ST_SLOW && hold_slow) |=> state_ff.st == MDC_ST_SLOW)
    else $error("left slow first cycle while held");
  ipd_hold_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    (state_ff.st == MDC_ST_IPD && hold_ipd) |=> state_ff.st == MDC_ST_IPD)
    else $error("left position detect while held");
  isd_hold_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    (state_ff.st == MDC_ST_ISD && hold_isd) |=> state_ff.st == MDC_ST_ISD)
    else $error("left speed detect while held");
  angle_sel_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    ##1 state_ff.ctrl[MDC_ANGLE_SEL_BIT] |-> o_lock_angle == $past(i_alternate_rotor_lock_angle))
    else $error("alternate angle not selected");
  reserved_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    state_ff.ctrl[MDC_ANGLE_SEL_BIT-1:0] == 10'h000)
    else $error("reserved bits not zero");
  // Main scenarios that the bench should reach
  cov_reference_flag_a_c: cover property (
    @(posedge i_clock) disable iff (!i_nrst) o_cmd_from_reg);
  cov_open_loop_c: cover property (
    @(posedge i_clock) disable iff (!i_nrst) o_feedback_loop_disable);
  cov_run_c: cover property (
    @(posedge i_clock) disable iff (!i_nrst) state_ff.st == MDC_ST_RUN);
  cov_isd_hold_c: cover property (@(posedge i_clock) disable iff (!i_nrst)
    state_ff.st == MDC_ST_ISD && hold_isd && i_stage_done);
  cov_align_hold_c: cover property (@(posedge i_clock) disable iff (!i_nrst)
    state_ff.st == MDC_ST_ALIGN && hold_align && i_stage_done);
endmodule : mdc_debug_ctrl

/* sim/mdc_host_model.sv */
// Host model issuing register writes and reads on the strobe port
`timescale 1ns/1ps
module mdc_host_model (
  input wire logic i_clock,
  input wire logic [31:0] i_rdata,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [7:0] o_addr,
  output logic [31:0] o_wdata
);
  // Strobes idle at start
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'h00;
    o_wdata = 32'h00000000;
  end
  // One strobe cycle, held over the sampling edge
  task automatic write(input logic [7:0] addr, input logic [31:0] data);
    @(posedge i_clock);
    #1 o_wr_en = 1'b1;
    o_addr = addr;
    o_wdata = data;
    @(posedge i_clock);
    #1 o_wr_en = 1'b0;
    o_wdata = ~data;  // Released data must not look valid
  endtask : write
  // Data is taken once the sampling edge has updated the read port
  task automatic read(input logic [7:0] addr, output logic [31:0] data);
    @(posedge i_clock);
    #1 o_rd_en = 1'b1;
    o_addr = addr;
    @(posedge i_clock);
    #1 o_rd_en = 1'b0;
    data = i_rdata;
  endtask : read
endmodule : mdc_host_model

/* sim/mdc_debug_ctrl_tb.sv */
// Self-checking bench for the debug control register block
`timescale 1ns/1ps
module mdc_debug_ctrl_tb;
  import mdc_pkg::*;
  logic clock, nrst, wr_en, rd_en, start, done, speed_detect_enable, from_reg, loop_dis;
  logic [7:0] addr, angle;
  logic [7:0] align_angle, alt_angle;
  logic [31:0] wdata, rdata, d;
  logic [1:0] mode, method;
  logic [14:0] ext_ref, speed_cmd;
  logic [2:0] state;
  int miscompares, comparisons, cycles;
  mdc_host_model mdc_host_model_inst (.i_clock(clock), .i_rdata(rdata), .o_wr_en(wr_en),
    .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));
  mdc_debug_ctrl mdc_debug_ctrl_inst (.i_clock(clock), .i_nrst(nrst), .i_wr_en(wr_en),
    .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata), .i_source_mode(mode),
    .i_ext_ref(ext_ref), .i_startup_method_select(method), .i_speed_detect_enable(speed_detect_enable),
    .i_start(start), .i_stage_done(done), .i_align_angle(align_angle),
    .i_alternate_rotor_lock_angle(alt_angle), .o_rdata(rdata), .o_speed_cmd(speed_cmd),
    .o_cmd_from_reg(from_reg), .o_feedback_loop_disable(loop_dis), .o_lock_angle(angle),
    .o_startup_state(state));
  // Free-running clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Hang guard; the whole run needs about 120 cycles, so 3000 means a stall
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic summarize();
    if (miscompares == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  task automatic do_reset();
    #1 nrst = 1'b0;
    repeat (3) @(posedge clock);
    #1 nrst = 1'b1;
  endtask : do_reset
  task automatic t_reset();
    do_reset();
    check({state, loop_dis, from_reg, speed_cmd, angle}, 32'h0);
    mdc_host_model_inst.read(8'hEC, d);
    check(d, 32'h00000000);
  endtask : t_reset
  // Reference_flag_a, source mode, loop disable, reserved bits, unmapped write and read
  task automatic t_source();
    mdc_host_model_inst.write(8'hEC, 32'h923483FF);
    check({from_reg, speed_cmd}, {1'b1, 15'h1234});
    check(loop_dis, 1'b1);
    mdc_host_model_inst.read(8'hEC, d);
    check(d, 32'h92348000);
    // Read data stands for one cycle only
    @(posedge clock);
    #1 check(rdata, 32'h00000000);
    mdc_host_model_inst.write(8'hEC, 32'h12340000);
    check({from_reg, speed_cmd, loop_dis}, {1'b0, 15'h0555, 1'b0});
    @(posedge clock);
    #1 mode = 2'h2;
    @(posedge clock);
    #1 check({from_reg, speed_cmd}, {1'b1, 15'h1234});
    mode = 2'h0;
    @(posedge clock);
    #1 check({from_reg, speed_cmd}, {1'b0, 15'h0555});
    mdc_host_model_inst.write(8'hEE, 32'hFFFFFFFF);
    mdc_host_model_inst.read(8'hEE, d);
    check(d, 32'h00000000);
    mdc_host_model_inst.read(8'hEC, d);
    check(d, 32'h12340000);
  endtask : t_source
  // Angle choice and that the chosen input is followed live
  task automatic t_angle();
    mdc_host_model_inst.write(8'hEC, 32'h00000400);
    check(angle, 8'hC3);
    alt_angle = 8'h5A;
    @(posedge clock);
    #1 check(angle, 8'h5A);
    mdc_host_model_inst.write(8'hEC, 32'h00000000);
    check(angle, 8'h3C);
  endtask : t_angle
  // Startup run with every stage reporting done
  task automatic t_start(input logic [1:0] m, input logic s, input logic [31:0] h,
    input logic [2:0] exp);
    do_reset();
    mdc_host_model_inst.write(8'hEC, h);
    method = m;
    speed_detect_enable = s;
    start = 1'b1;
    @(posedge clock);
    #1 start = 1'b0;
    done = 1'b1;
    repeat (6) @(posedge clock);
    #1 done = 1'b0;
    check(state, exp);
  endtask : t_start
  // Main sequence
  initial begin
    {nrst, start, done, speed_detect_enable, mode, method} = '0;
    ext_ref = 15'h0555;
    align_angle = 8'h3C;
    alt_angle = 8'hC3;
    t_reset();
    t_source();
    t_angle();
    t_start(2'h0, 1'b0, 32'h4000, 3'h2);
    t_start(2'h1, 1'b0, 32'h4000, 3'h2);
    t_start(2'h0, 1'b0, 32'h0000, 3'h5);
    t_start(2'h2, 1'b0, 32'h4000, 3'h5);
    t_start(2'h2, 1'b0, 32'h2000, 3'h3);
    t_start(2'h3, 1'b0, 32'h1000, 3'h4);
    t_start(2'h3, 1'b1, 32'h0800, 3'h1);
    t_start(2'h0, 1'b1, 32'h0000, 3'h5);
    summarize();
  end
endmodule : mdc_debug_ctrl_tb
